// ==== src/seq_defs.svh ====
`ifndef SEQ_DEFS_SVH
`define SEQ_DEFS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_REMOTE_BITS 8'h00
`define OFS_POS_LOW 8'h04
`define OFS_POS_HIGH 8'h08
`define OFS_SPEED 8'h0C
`define OFS_PARAMS 8'h10
`define OFS_TABLE_SEL 8'h14
`define OFS_STATUS 8'h18
`define OFS_TARGET 8'h1C
`define OFS_CUR_POS 8'h20
`define OFS_REMAINING 8'h24
`define OFS_TBL_ADDR 8'h28
`define OFS_TBL_DATA 8'h2C

// ----------------------------------------
// field positions and codes
// ----------------------------------------
`define REMOTE_BITS_W 6
`define TBL_FIELD_LSB 0
`define TBL_INDEX_LSB 4
`define DIGIT_ABSOLUTE 4'h0
`define DIGIT_REG_SOURCE 4'h2
`define STATIONS_FOR_REG 4'h2
`define AUX_CHAIN 2'h1
`define POS_LIMIT 32'sd999999

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_PARAMS 12'h100
`define RST_WORD 16'h0000

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 40
`define NS_PER_MS 1000000
`define CYCLES_PER_MS (`NS_PER_MS / `CLK_PERIOD_NS)

`endif

// ==== src/seq_pkg.sv ====
package seq_pkg;

  // ----------------------------------------
  // remote bit image and parameters
  // ----------------------------------------
  typedef struct packed {
    logic abs_inc_select_bit;
    logic position_speed_source_bit;
    logic pause_resume_bit;
    logic auto_manual_select_bit;
    logic reverse_start_bit;
    logic forward_start_bit;
  } remote_bits_t;

  typedef struct packed {
    logic [3:0] stations;
    logic [3:0] position_source_param;
    logic [3:0] command_system_param;
  } params_t;

  typedef struct packed {
    logic signed [31:0] position;
    logic [15:0] speed;
    logic [15:0] accel_ms;
    logic [15:0] decel_ms;
    logic [15:0] dwell_ms;
    logic [1:0] aux;
  } table_entry_t;

  typedef enum logic [2:0] {
    FLD_POSITION = 3'h0,
    FLD_SPEED = 3'h1,
    FLD_ACCEL = 3'h2,
    FLD_DECEL = 3'h3,
    FLD_DWELL = 3'h4,
    FLD_AUX = 3'h5
  } table_field_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CHAIN = 3'b001,
    ST_LOAD = 3'b010,
    ST_RUN = 3'b011,
    ST_SWITCH = 3'b100,
    ST_STOPPING = 3'b101,
    ST_PAUSED = 3'b110
  } seq_state_t;

endpackage

// ==== src/point_table_ram.sv ====
`timescale 1ns/1ns
module point_table_ram #(
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_index,
  input wire seq_pkg::table_field_t wr_field,
  input wire logic [31:0] wr_data,
  input wire logic [$clog2(DEPTH)-1:0] rd_index,
  output seq_pkg::table_entry_t rd_entry
);
  // ----------------------------------------
  // table storage
  // ----------------------------------------
  seq_pkg::table_entry_t mem_reg [DEPTH];

  initial begin
    if (DEPTH < 2 || DEPTH > 256) $error("point table depth out of range");
  end

  // field-wise writes so software can patch one value without a read-modify-write
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < DEPTH; i++) mem_reg[i] <= '0;
    end else if (wr_en) begin
      case (wr_field)
        seq_pkg::FLD_POSITION: mem_reg[wr_index].position <= wr_data;
        seq_pkg::FLD_SPEED: mem_reg[wr_index].speed <= wr_data[15:0];
        seq_pkg::FLD_ACCEL: mem_reg[wr_index].accel_ms <= wr_data[15:0];
        seq_pkg::FLD_DECEL: mem_reg[wr_index].decel_ms <= wr_data[15:0];
        seq_pkg::FLD_DWELL: mem_reg[wr_index].dwell_ms <= wr_data[15:0];
        seq_pkg::FLD_AUX: mem_reg[wr_index].aux <= wr_data[1:0];
        default: ;
      endcase
    end
  end

  assign rd_entry = mem_reg[rd_index];
endmodule

// ==== src/motion_stepper.sv ====
`timescale 1ns/1ns
module motion_stepper (
  input wire logic clk,
  input wire logic reset,
  input wire logic load,
  input wire logic signed [31:0] distance,
  input wire logic clear,
  input wire logic hold,
  input wire logic [15:0] speed,
  output logic signed [31:0] position_reg,
  output logic signed [31:0] remaining_reg,
  output logic [15:0] step_mag
);
  // ----------------------------------------
  // step toward zero remaining, never past it
  // ----------------------------------------
  wire logic negative = remaining_reg[31];
  wire logic [31:0] rem_mag = negative ? 32'(-remaining_reg) : remaining_reg;
  wire logic limited = rem_mag < {16'h0000, speed};
  wire logic [31:0] step32 = hold ? 32'h0000_0000 : (limited ? rem_mag : {16'h0000, speed});
  wire logic signed [31:0] delta = negative ? 32'(-step32) : step32;

  assign step_mag = step32[15:0];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      position_reg <= 32'sh0000_0000;
      remaining_reg <= 32'sh0000_0000;
    end else begin
      position_reg <= position_reg + delta;
      if (clear) remaining_reg <= 32'sh0000_0000;
      else if (load) remaining_reg <= distance;
      else remaining_reg <= remaining_reg - delta;
    end
  end
endmodule

// ==== src/point_table_positioning_sequencer.sv ====
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ns
`include "seq_defs.svh"
module point_table_positioning_sequencer #(
  parameter int DEPTH = 8,
  parameter int CYCLES_PER_MS = `CYCLES_PER_MS
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic home_active,
  input wire logic jog_active,
  output logic [31:0] rdata,
  output logic signed [31:0] position_cmd,
  output logic [15:0] speed_cmd,
  output logic [15:0] accel_ms,
  output logic [15:0] decel_ms,
  output logic in_motion,
  output logic paused,
  output logic move_done,
  output logic target_error
);
  localparam int IW = $clog2(DEPTH);

  initial begin
    if (CYCLES_PER_MS < 1) $error("cycles per ms must be at least one");
  end

  // ----------------------------------------
  // pin inputs from outside the clock domain
  // ----------------------------------------
  logic [1:0] home_sync_reg;
  logic [1:0] jog_sync_reg;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      home_sync_reg <= 2'h0;
      jog_sync_reg <= 2'h0;
    end else begin
      home_sync_reg <= {home_sync_reg[0], home_active};
      jog_sync_reg <= {jog_sync_reg[0], jog_active};
    end
  end

  wire logic manual_motion = home_sync_reg[1] | jog_sync_reg[1];

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  seq_pkg::remote_bits_t bits_reg;
  seq_pkg::remote_bits_t bits_prev_reg;
  seq_pkg::params_t params_reg;
  logic [15:0] pos_low_reg;
  logic [15:0] pos_high_reg;
  logic [15:0] speed_word_reg;
  logic [IW-1:0] table_sel_reg;
  logic [31:0] tbl_addr_reg;

  wire logic wr_bits = wr && addr == `OFS_REMOTE_BITS;
  wire logic wr_tbl = wr && addr == `OFS_TBL_DATA;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bits_reg <= '0;
      params_reg <= `RST_PARAMS;
      pos_low_reg <= `RST_WORD;
      pos_high_reg <= `RST_WORD;
      speed_word_reg <= `RST_WORD;
      table_sel_reg <= '0;
      tbl_addr_reg <= 32'h0000_0000;
    end else if (wr) begin
      case (addr)
        `OFS_REMOTE_BITS: bits_reg <= wdata[`REMOTE_BITS_W-1:0];
        `OFS_POS_LOW: pos_low_reg <= wdata[15:0];
        `OFS_POS_HIGH: pos_high_reg <= wdata[15:0];
        `OFS_SPEED: speed_word_reg <= wdata[15:0];
        `OFS_PARAMS: params_reg <= wdata[11:0];
        `OFS_TABLE_SEL: table_sel_reg <= wdata[IW-1:0];
        `OFS_TBL_ADDR: tbl_addr_reg <= wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) bits_prev_reg <= '0;
    else bits_prev_reg <= bits_reg;
  end

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  wire logic fwd_edge = bits_reg.forward_start_bit & ~bits_prev_reg.forward_start_bit;
  wire logic rev_edge = bits_reg.reverse_start_bit & ~bits_prev_reg.reverse_start_bit;
  wire logic pause_edge = bits_reg.pause_resume_bit & ~bits_prev_reg.pause_resume_bit;
  wire logic auto_mode = bits_reg.auto_manual_select_bit;
  wire logic abs_system = params_reg.command_system_param == `DIGIT_ABSOLUTE;
  wire logic reg_mode = auto_mode && bits_reg.position_speed_source_bit
    && params_reg.position_source_param == `DIGIT_REG_SOURCE
    && params_reg.stations == `STATIONS_FOR_REG;
  wire logic signed [31:0] reg_position = {pos_high_reg, pos_low_reg};
  wire logic reg_in_range = reg_position <= `POS_LIMIT && reg_position >= -`POS_LIMIT;
  // reverse start has no meaning for an absolute target, so only forward starts one
  wire logic start_ok = auto_mode && (fwd_edge || (rev_edge && !(reg_mode && abs_system)));

  // ----------------------------------------
  // sequencer state
  // ----------------------------------------
  seq_pkg::seq_state_t state_reg;
  seq_pkg::seq_state_t state_next;
  seq_pkg::table_entry_t entry;
  logic [IW-1:0] idx_reg;
  logic signed [31:0] sum_reg;
  logic signed [31:0] seg_left_reg;
  logic signed [31:0] target_reg;
  logic reverse_reg;
  logic incremental_reg;
  logic chain_more_reg;
  logic [31:0] stop_cnt_reg;
  logic stepper_load;
  logic signed [31:0] stepper_dist;
  logic signed [31:0] stepper_pos;
  logic signed [31:0] stepper_rem;
  logic [15:0] step_mag;

  wire logic last_idx = idx_reg == IW'(DEPTH - 1);
  wire logic chained = entry.aux == `AUX_CHAIN && !last_idx;
  wire logic signed [31:0] sum_total = sum_reg + entry.position;
  wire logic [31:0] stop_limit = 32'(decel_ms) * 32'(CYCLES_PER_MS);
  wire logic stop_done = stop_cnt_reg >= stop_limit;
  wire logic moving = stepper_rem != 32'sh0000_0000;
  wire logic pause_ok = pause_edge && auto_mode && !manual_motion;
  // absolute only when the command system is absolute and the select bit does not ask for incremental
  wire logic use_abs = abs_system && !bits_reg.abs_inc_select_bit;
  wire logic signed [31:0] reg_dist = use_abs ? reg_position - stepper_pos
    : (bits_reg.reverse_start_bit && !abs_system ? -reg_position : reg_position);
  wire logic reg_start = start_ok && reg_mode && (reg_in_range || !abs_system)
    && state_reg == seq_pkg::ST_IDLE;
  wire logic table_start = start_ok && !reg_mode && state_reg == seq_pkg::ST_IDLE;
  wire logic hold = state_reg == seq_pkg::ST_PAUSED;
  wire logic clear_rem = state_reg == seq_pkg::ST_PAUSED && !auto_mode;
  // during the stop ramp the motor runs on at half speed before standing still
  wire logic [15:0] run_speed = state_reg == seq_pkg::ST_STOPPING ? speed_cmd >> 1 : speed_cmd;

  assign stepper_load = reg_start || state_reg == seq_pkg::ST_LOAD;
  assign stepper_dist = state_reg == seq_pkg::ST_LOAD ? (reverse_reg ? -sum_reg : sum_reg)
    : reg_dist;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      seq_pkg::ST_IDLE: begin
        if (reg_start) state_next = seq_pkg::ST_RUN;
        else if (table_start) state_next = seq_pkg::ST_CHAIN;
      end
      seq_pkg::ST_CHAIN: begin
        if (!chained) state_next = seq_pkg::ST_LOAD;
      end
      seq_pkg::ST_LOAD: state_next = seq_pkg::ST_RUN;
      seq_pkg::ST_RUN: begin
        if (!moving) state_next = seq_pkg::ST_IDLE;
        else if (pause_ok) state_next = seq_pkg::ST_STOPPING;
        else if (seg_left_reg <= 32'sh0000_0000 && chain_more_reg) state_next = seq_pkg::ST_SWITCH;
      end
      seq_pkg::ST_SWITCH: state_next = seq_pkg::ST_RUN;
      seq_pkg::ST_STOPPING: begin
        if (!moving) state_next = seq_pkg::ST_IDLE;
        else if (stop_done) state_next = seq_pkg::ST_PAUSED;
      end
      seq_pkg::ST_PAUSED: begin
        // start bits are not looked at here, only pause, mode and the home and jog inputs
        if (!auto_mode) state_next = seq_pkg::ST_IDLE;
        else if (pause_ok) state_next = seq_pkg::ST_RUN;
      end
      default: state_next = seq_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) state_reg <= seq_pkg::ST_IDLE;
    else state_reg <= state_next;
  end

  // ----------------------------------------
  // chain walk and segment tracking
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      idx_reg <= '0;
      sum_reg <= 32'sh0000_0000;
      seg_left_reg <= 32'sh0000_0000;
      reverse_reg <= 1'b0;
      chain_more_reg <= 1'b0;
    end else begin
      case (state_reg)
        seq_pkg::ST_IDLE: begin
          idx_reg <= table_sel_reg;
          sum_reg <= 32'sh0000_0000;
          reverse_reg <= !bits_reg.forward_start_bit;
          chain_more_reg <= 1'b0;
        end
        seq_pkg::ST_CHAIN: begin
          sum_reg <= sum_total;
          if (chained) idx_reg <= idx_reg + 1'b1;
          else idx_reg <= table_sel_reg;
        end
        seq_pkg::ST_LOAD: begin
          seg_left_reg <= entry.position;
          chain_more_reg <= chained;
        end
        seq_pkg::ST_RUN: begin
          seg_left_reg <= seg_left_reg - $signed({16'h0000, step_mag});
          if (seg_left_reg <= 32'sh0000_0000 && chain_more_reg) idx_reg <= idx_reg + 1'b1;
        end
        seq_pkg::ST_SWITCH: begin
          seg_left_reg <= seg_left_reg + entry.position;
          chain_more_reg <= chained;
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // move parameters sampled at start, speed also at each segment switch
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      incremental_reg <= 1'b0;
      target_reg <= 32'sh0000_0000;
      speed_cmd <= `RST_WORD;
      accel_ms <= `RST_WORD;
      decel_ms <= `RST_WORD;
    end else if (reg_start && state_reg == seq_pkg::ST_IDLE) begin
      incremental_reg <= !use_abs;
      target_reg <= stepper_pos + reg_dist;
      speed_cmd <= speed_word_reg;
      accel_ms <= entry.accel_ms;
      decel_ms <= entry.decel_ms;
    end else if (state_reg == seq_pkg::ST_LOAD) begin
      incremental_reg <= 1'b1;
      target_reg <= stepper_pos + stepper_dist;
      speed_cmd <= entry.speed;
      accel_ms <= entry.accel_ms;
      decel_ms <= entry.decel_ms;
    end else if (state_reg == seq_pkg::ST_SWITCH) begin
      speed_cmd <= entry.speed;
    end
  end

  // ----------------------------------------
  // stop timer and status flags
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) stop_cnt_reg <= 32'h0000_0000;
    else if (state_reg == seq_pkg::ST_STOPPING) stop_cnt_reg <= stop_cnt_reg + 32'h0000_0001;
    else stop_cnt_reg <= 32'h0000_0000;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      in_motion <= 1'b0;
      paused <= 1'b0;
      move_done <= 1'b0;
      target_error <= 1'b0;
      position_cmd <= 32'sh0000_0000;
    end else begin
      in_motion <= state_next == seq_pkg::ST_RUN || state_next == seq_pkg::ST_STOPPING
        || state_next == seq_pkg::ST_SWITCH;
      paused <= state_next == seq_pkg::ST_PAUSED;
      move_done <= state_next == seq_pkg::ST_IDLE && (state_reg == seq_pkg::ST_RUN
        || state_reg == seq_pkg::ST_STOPPING);
      // sticky until the next accepted start
      if (start_ok && reg_mode && abs_system && !reg_in_range && state_reg == seq_pkg::ST_IDLE)
        target_error <= 1'b1;
      else if (reg_start || table_start) target_error <= 1'b0;
      position_cmd <= stepper_pos;
    end
  end

  // ----------------------------------------
  // submodules
  // ----------------------------------------
  wire logic [IW-1:0] rd_index = state_reg == seq_pkg::ST_IDLE ? (reg_mode ? '0 : table_sel_reg)
    : idx_reg;

  point_table_ram #(
    .DEPTH(DEPTH)
  ) u_table (
    .clk(clk),
    .reset(reset),
    .wr_en(wr_tbl),
    .wr_index(tbl_addr_reg[`TBL_INDEX_LSB +: IW]),
    .wr_field(seq_pkg::table_field_t'(tbl_addr_reg[`TBL_FIELD_LSB +: 3])),
    .wr_data(wdata),
    .rd_index(rd_index),
    .rd_entry(entry)
  );

  motion_stepper u_stepper (
    .clk(clk),
    .reset(reset),
    .load(stepper_load),
    .distance(stepper_dist),
    .clear(clear_rem),
    .hold(hold),
    .speed(run_speed),
    .position_reg(stepper_pos),
    .remaining_reg(stepper_rem),
    .step_mag(step_mag)
  );

  // ----------------------------------------
  // read path
  // ----------------------------------------
  wire logic [31:0] status_word = {22'h000000, target_error, incremental_reg, paused,
    in_motion, reg_mode, state_reg, reverse_reg, wr_bits};
  logic [31:0] rd_mux;

  always_comb begin
    case (addr)
      `OFS_REMOTE_BITS: rd_mux = {26'h0000000, bits_reg};
      `OFS_POS_LOW: rd_mux = {16'h0000, pos_low_reg};
      `OFS_POS_HIGH: rd_mux = {16'h0000, pos_high_reg};
      `OFS_SPEED: rd_mux = {16'h0000, speed_word_reg};
      `OFS_PARAMS: rd_mux = {20'h00000, params_reg};
      `OFS_TABLE_SEL: rd_mux = 32'(table_sel_reg);
      `OFS_STATUS: rd_mux = {status_word[31:1], 1'b0};
      `OFS_TARGET: rd_mux = target_reg;
      `OFS_CUR_POS: rd_mux = stepper_pos;
      `OFS_REMAINING: rd_mux = stepper_rem;
      `OFS_TBL_ADDR: rd_mux = tbl_addr_reg;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) rdata <= 32'h0000_0000;
    else if (rd) rdata <= rd_mux;
    else rdata <= 32'h0000_0000;
  end
endmodule

// ==== test/sequencer_monitor.sv ====
`timescale 1ns/1ns
module sequencer_monitor (
  input wire logic clk,
  input wire logic reset,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic signed [31:0] position_cmd,
  input wire logic in_motion,
  input wire logic paused,
  input wire logic move_done,
  input wire logic target_error
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // ----------------------------------------
  // port relations
  // ----------------------------------------
  a_read_quiet: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data outside the answer cycle");
  a_pause_excl: assert property (!(paused && in_motion))
    else $error("paused and moving together");
  a_pause_entry: assert property ($rose(paused) |-> $past(in_motion))
    else $error("stop entered without a decelerating move");
  a_pause_still: assert property (paused [*3] |-> $stable(position_cmd))
    else $error("position moved during a temporary stop");
  a_done_pulse: assert property (move_done |=> !move_done)
    else $error("done longer than one cycle");
  a_done_idle: assert property (move_done |=> !in_motion && !paused)
    else $error("still moving after done");
  a_error_still: assert property ($rose(target_error) |-> !in_motion)
    else $error("refused target still moving");
  a_error_clear: assert property ($fell(target_error) |-> ##[0:2] in_motion)
    else $error("error cleared without a start");
endmodule

bind point_table_positioning_sequencer sequencer_monitor u_sequencer_monitor (.clk, .reset,
  .rd, .rdata, .position_cmd, .in_motion, .paused, .move_done, .target_error);

// ==== test/fieldbus_master.sv ====
`timescale 1ns/1ns
module fieldbus_master (
  input wire logic clk,
  input wire logic [31:0] rdata,
  output logic [7:0] addr,
  output logic [31:0] wdata,
  output logic wr,
  output logic rd
);
  initial begin
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
  end
  task automatic write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    wdata <= ~d; // released data must not look like a held value
  endtask
  task automatic read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  // words always land before the caller raises a start
  task automatic set_target(input logic signed [31:0] p, input logic [15:0] s);
    write(8'h04, {16'h0, p[15:0]});
    write(8'h08, {16'h0, p[31:16]});
    write(8'h0C, {16'h0, s});
  endtask
endmodule

// ==== test/point_table_positioning_sequencer_test.sv ====
`timescale 1ns/1ns
module point_table_positioning_sequencer_test;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic home_active = 1'b0;
  logic jog_active = 1'b0;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic signed [31:0] position_cmd;
  logic [15:0] speed_cmd;
  logic [15:0] accel_ms;
  logic [15:0] decel_ms;
  logic in_motion;
  logic paused;
  logic move_done;
  logic target_error;
  int n_fail = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [31:0] rnd = 32'hF22A2017;
  logic [31:0] d;
  logic signed [31:0] pos = 32'sh0;
  logic signed [31:0] sum = 32'sh0;
  logic signed [31:0] t;

  always #20 clk = ~clk;

  point_table_positioning_sequencer #(.DEPTH(8), .CYCLES_PER_MS(2))
    u_point_table_positioning_sequencer (.clk, .reset, .addr, .wdata, .wr, .rd,
    .home_active, .jog_active, .rdata, .position_cmd, .speed_cmd, .accel_ms,
    .decel_ms, .in_motion, .paused, .move_done, .target_error);
  fieldbus_master u_fieldbus_master (.clk, .rdata, .addr, .wdata, .wr, .rd);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    if (n_fail == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] v);
    u_fieldbus_master.write(a, v);
  endtask
  task automatic sf(input int i, input seq_pkg::table_field_t f, input logic [31:0] v);
    w(8'h28, {25'h0, 3'(i), 1'b0, f});
    w(8'h2C, v);
  endtask
  // start bits act on edges, so drop them first
  task automatic start(input logic [31:0] bits);
    w(8'h00, bits & 32'h3C);
    w(8'h00, bits);
  endtask
  task automatic reg_move(input logic [31:0] bits);
    u_fieldbus_master.set_target(t, {2'b01, rnd[29:16]});
    start(bits);
    w(8'h00, bits & 32'h1F); // select dropped mid-move
  endtask
  task automatic finish_move;
    int n;
    for (n = 0; n < 4000 && move_done !== 1'b1; n++) @(negedge clk);
    check({31'h0, move_done}, 32'h1);
    repeat (3) @(negedge clk);
    check(position_cmd, pos);
  endtask
  task automatic pause_now;
    int n;
    repeat (20) @(negedge clk);
    w(8'h00, 32'h0C);
    for (n = 0; n < 400 && paused !== 1'b1; n++) @(negedge clk);
    check({31'h0, paused}, 32'h1);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_fail++;
      conclude();
    end
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    u_fieldbus_master.read(8'h10, d);
    check(d, 32'h100);
    u_fieldbus_master.read(8'hFC, d);
    check(d, 32'h0);
    sf(0, seq_pkg::FLD_DECEL, 32'h3);
    sf(0, seq_pkg::FLD_ACCEL, 32'h5);
    w(8'h10, 32'h220);
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      t = $signed({{12{rnd[19]}}, rnd[19:0]});
      if (i < 2) t = (i == 0) ? 32'sd999999 : -32'sd999999;
      reg_move((rnd[20] && i > 1) ? 32'h35 : 32'h15);
      pos = (rnd[20] && i > 1) ? pos + t : t;
      finish_move();
      check({16'h0, speed_cmd}, {16'h0, 2'b01, rnd[29:16]});
    end
    check({16'h0, accel_ms}, 32'h5);
    t = 32'sd1000000;
    reg_move(32'h15);
    repeat (4) @(negedge clk);
    check({31'h0, target_error}, 32'h1);
    check(position_cmd, pos);
    w(8'h10, 32'h221);
    reg_move(32'h15);
    pos = pos + t;
    finish_move();
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      t = {22'h0, rnd[9:0]} + 32'd1000;
      sum = sum + t;
      sf(i, seq_pkg::FLD_POSITION, t);
      sf(i, seq_pkg::FLD_SPEED, 32'h8 << i);
      sf(i, seq_pkg::FLD_DWELL, 32'h0);
      sf(i, seq_pkg::FLD_AUX, {31'h0, i < 2});
    end
    w(8'h14, 32'h0);
    w(8'h10, 32'h021);
    start(32'h15);
    pos = pos + sum;
    finish_move();
    check({16'h0, speed_cmd}, 32'h20);
    start(32'h16);
    pos = pos - sum;
    finish_move();
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      home_active <= (k == 0);
      jog_active <= (k == 1);
      start(32'h05);
      repeat (20) @(negedge clk);
      w(8'h00, 32'h0C);
      pos = pos + sum;
      finish_move();
    end
    @(posedge clk);
    home_active <= 1'b0;
    jog_active <= 1'b0;
    start(32'h05);
    pause_now();
    check({16'h0, decel_ms}, 32'h3);
    w(8'h00, 32'h0D);
    repeat (10) @(negedge clk);
    check({31'h0, in_motion}, 32'h0);
    check({31'h0, paused}, 32'h1);
    w(8'h00, 32'h04);
    w(8'h00, 32'h0C);
    pos = pos + sum;
    finish_move();
    start(32'h05);
    pause_now();
    w(8'h00, 32'h00);
    w(8'h24, 32'h1234);
    repeat (5) @(negedge clk);
    check({31'h0, paused}, 32'h0);
    u_fieldbus_master.read(8'h24, d);
    check(d, 32'h0);
    conclude();
  end
endmodule
